// >>> pfc_pkg.sv
// Constants and carrier types for the synthesizer fabric control block.
// Assumes one 20 MHz system clock and a classic Wishbone master.
package pfc_pkg;
  localparam logic [7:0] ADR_DIVCFG = 8'h00; // Dividers and modes.
  localparam logic [7:0] ADR_FEEDBACK_DIVIDER = 8'h04; // Feedback ratio.
  localparam logic [7:0] ADR_FRACTION_WORD = 8'h08; // Fraction word.
  localparam logic [7:0] ADR_DLYINIT = 8'h0c; // Configured delay.
  localparam logic [7:0] ADR_PHINIT = 8'h10; // Configured phases.
  localparam logic [7:0] ADR_STATUS = 8'h14; // Live state.
  localparam int ERR_BIT = 2; // Status error bit, write one clears.
  localparam logic [5:0] REF_DIV_RST = 6'h01; // Divider ratio at reset.
  localparam logic [5:0] REF_DIV_MAX = 6'h3f; // Largest divider ratio.
  localparam logic [11:0] FB_DIV_RST = 12'h014; // Valid in both modes.
  localparam logic [11:0] FB_INT_LO = 12'h008; // Integer lower band.
  localparam logic [11:0] FB_INT_HI1 = 12'h00a; // Integer band end.
  localparam logic [11:0] FB_INT_LO2 = 12'h00c; // Integer upper band.
  localparam logic [11:0] FB_INT_MAX = 12'hfff; // Integer ceiling.
  localparam logic [11:0] FB_FRACTION_WORD_LO = 12'h014; // Fractional floor.
  localparam logic [11:0] FB_FRACTION_WORD_HI = 12'h1f4; // Fractional ceiling.
  localparam logic [3:0] LOCK_EXP_RST = 4'h8; // Two to the eighth.
  localparam logic [3:0] LOCK_EXP_MIN = 4'h1; // Two cycles.
  localparam logic [3:0] LOCK_EXP_MAX = 4'hf; // 32768 cycles.
  localparam logic [7:0] DLY_INIT_RST = 8'h40; // Delay at reset.
  localparam logic [7:0] DLY_MAX = 8'hff; // Last delay tap.
  localparam logic [4:0] VCO_WINDOW = 5'h10; // Start alignment span.
  typedef struct packed {
    logic cyc; // Cycle.
    logic stb; // Strobe.
    logic we; // Write enable.
    logic [7:0] adr; // Byte address.
    logic [3:0] sel; // Byte lanes.
    logic [31:0] dat; // Write data.
  } pfc_wb_t;
  typedef struct packed {
    logic pend; // One-cycle write request.
    logic [7:0] adr; // Target address.
    logic [31:0] dat; // Word to write.
  } pfc_wr_t;
endpackage

// >>> pfc_ctrl.sv
// Fabric control of one frequency synthesizer: registers, dividers,
// lock, output gating, delay and phase stepping, reconfiguration port.
// Assumes all fabric inputs are synchronous to CLOCK except the strobes, phase restore and the reconfig clock and reset.
`timescale 1ns/1ps
module pfc_ctrl
  import pfc_pkg::*;
(
  input wire logic CLOCK, // System clock, 20 MHz.
  input wire logic RESETN, // Synchronous reset, active low.
  input wire logic CE, // Clock enable; low freezes all state but the reconfig write request.
  input wire pfc_wb_t WB_I, // Wishbone request from the master.
  output logic WB_ACK_O, // Wishbone acknowledge.
  output logic [31:0] WB_DAT_O, // Wishbone read data.
  input wire logic REF_CLK_0, // Primary reference, sampled.
  input wire logic REF_CLK_1, // Backup reference, sampled.
  input wire logic REF_SELECT, // Reference select.
  input wire logic FEEDBACK_CLOCK_IN, // External feedback sample.
  input wire logic LOOP_SLEEP_N, // Power-down, active low.
  input wire logic [3:0] OUT_EN, // Output enables.
  input wire logic BYPASS_APPLY_N, // Bypass apply, active low.
  input wire logic REF_DIVIDER_SYNC_ENABLE, // Divider sync enable.
  input wire logic DELAY_STEP_STROBE, // Delay step, asynchronous.
  input wire logic DELAY_DIRECTION, // Delay step direction.
  input wire logic DELAY_DOUBLE, // Two taps per step.
  input wire logic DELAY_RESTORE, // Reload configured delay.
  input wire logic [3:0] PHASE_SELECT, // Outputs taking a rotation.
  input wire logic PHASE_DIRECTION, // Rotation direction.
  input wire logic PHASE_STEP_STROBE, // Rotate, asynchronous.
  input wire logic PHASE_RESTORE_N, // Phase restore, active low.
  input wire logic RECONFIG_CLOCK, // Reconfiguration clock, sampled.
  input wire logic RECONFIG_RESET_N, // Reconfig reset, async, low.
  input wire logic [10:0] RECONFIG_CONTROL, // Reconfig control bits.
  input wire logic [32:0] RECONFIG_WRITE_BUS, // Address or data in.
  output logic [32:0] RECONFIG_READ_BUS, // Read data out.
  output logic RECONFIG_IRQ, // Reconfig interrupt.
  output logic [3:0] CLK_OUT, // Gated synthesizer outputs.
  output logic LOCK, // Delayed lock indication.
  output logic [1:0] REF_DIV_RUN, // Divider run, both synthesizers.
  output logic DELAY_LIMIT_REACHED, // Delay at an end tap.
  output logic [7:0] DELAY_TAP, // Current delay tap.
  output logic [11:0] PHASE_OFFSET // Phase per output, 3 bits each.
);
  // Whole state of the control logic.
  typedef struct packed {
    logic ack; // Bus acknowledge.
    logic [31:0] rdat; // Bus read data.
    logic [5:0] ref_div; // Reference divider ratio.
    logic fraction_word_mode; // Fractional mode.
    logic ext_fb; // External feedback mode.
    logic [3:0] lock_exp; // Lock delay exponent.
    logic [3:0] byp_sel; // Preset bypass mux per output.
    logic [11:0] fb_div; // Feedback ratio.
    logic [23:0] fraction_word; // Fraction word.
    logic [7:0] dly_init; // Configured delay.
    logic [11:0] ph_init; // Configured phases.
    logic err; // A write was refused.
    logic [2:0] ds_sync; // Delay strobe synchroniser.
    logic [2:0] ps_sync; // Phase strobe synchroniser.
    logic [2:0] pr_sync; // Phase restore synchroniser.
    logic ref_q; // Previous reference sample.
    logic ref_sel_q; // Select in use.
    logic [5:0] div_cnt; // Reference divider count.
    logic div_run; // Divider released.
    logic [15:0] lock_cnt; // Divided cycles counted toward lock.
    logic lock; // Lock indication.
    logic [7:0] tap; // Delay tap.
    logic lim; // Delay limit flag.
    logic [11:0] phase; // Phase offsets.
    logic [3:0] clk; // Output levels.
    logic [3:0] run; // Output toggling.
    logic [7:0] stop_cnt; // Falling edges seen while stopping.
    logic [3:0] en_q; // Previous enables.
    logic [3:0] pend; // Enables waiting to start.
    logic win_open; // Alignment window open.
    logic [4:0] win_cnt; // Alignment window count.
  } pfc_state_t;

  // Reconfiguration port state, cleared by its own asynchronous reset.
  typedef struct packed {
    logic [1:0] ck_sync; // Reconfig clock synchroniser.
    logic ck_q; // Previous synchronised reconfig clock.
    logic [7:0] adr; // Address from the address phase.
    logic [32:0] rbus; // Read bus.
    logic irq; // Interrupt.
    logic lock_q; // Lock seen last cycle.
    pfc_wr_t wr; // Write handed to the register file.
  } pfc_rc_t;

  pfc_state_t st;
  pfc_state_t next_st;
  pfc_rc_t rc;
  pfc_rc_t next_rc;

  // Feedback ratio check for the given mode.
  function automatic logic fb_ok(input logic fm, input logic [11:0] v);
    if (fm) begin
      fb_ok = (v >= FB_FRACTION_WORD_LO) && (v <= FB_FRACTION_WORD_HI);
    end else begin
      fb_ok = ((v >= FB_INT_LO) && (v <= FB_INT_HI1)) ||
              ((v >= FB_INT_LO2) && (v <= FB_INT_MAX));
    end
  endfunction

  // Register read decode, shared by the bus and the reconfig port.
  function automatic logic [31:0] rd(input pfc_state_t s,
                                     input logic [7:0] a);
    rd = 32'h0;
    case (a)
      ADR_DIVCFG: rd = {16'h0, s.byp_sel, s.lock_exp, s.ext_fb,
                        s.fraction_word_mode, s.ref_div};
      ADR_FEEDBACK_DIVIDER: rd = {20'h0, s.fb_div};
      ADR_FRACTION_WORD: rd = {8'h0, s.fraction_word};
      ADR_DLYINIT: rd = {24'h0, s.dly_init};
      ADR_PHINIT: rd = {20'h0, s.ph_init};
      ADR_STATUS: rd = {4'h0, s.phase, s.tap, 2'h0, s.div_run,
                        s.ref_sel_q, ~LOOP_SLEEP_N, s.err, s.lim, s.lock};
      default: rd = 32'h0;
    endcase
  endfunction

  // Register write decode; out-of-range ratios are refused and flagged.
  function automatic pfc_state_t wr(input pfc_state_t s,
                                    input logic [7:0] a,
                                    input logic [31:0] d,
                                    input logic [3:0] be);
    logic [31:0] m;
    logic [31:0] w;
    wr = s;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    w = (rd(s, a) & ~m) | (d & m);
    case (a)
      ADR_DIVCFG: begin
        if ((w[5:0] != 6'h0) && (w[5:0] <= REF_DIV_MAX) &&
            (w[11:8] >= LOCK_EXP_MIN) && (w[11:8] <= LOCK_EXP_MAX) &&
            fb_ok(w[6], s.fb_div)) begin
          wr.ref_div = w[5:0];
          wr.fraction_word_mode = w[6];
          wr.ext_fb = w[7];
          wr.lock_exp = w[11:8];
          wr.byp_sel = w[15:12];
        end else begin
          wr.err = 1'b1;
        end
      end
      ADR_FEEDBACK_DIVIDER: begin
        if (fb_ok(s.fraction_word_mode, w[11:0])) begin
          wr.fb_div = w[11:0];
        end else begin
          wr.err = 1'b1;
        end
      end
      ADR_FRACTION_WORD: wr.fraction_word = w[23:0];
      ADR_DLYINIT: wr.dly_init = w[7:0];
      ADR_PHINIT: wr.ph_init = w[11:0];
      ADR_STATUS: begin
        if (be[0] && d[ERR_BIT]) begin
          wr.err = 1'b0;
        end
      end
      default: wr = s;
    endcase
  endfunction

  // Next state of the control logic; CE low holds everything.
  always_comb begin
    logic sref;
    logic rise;
    logic tick;
    logic [8:0] sum;
    logic [7:0] dlt;
    next_st = st;
    sref = REF_SELECT ? REF_CLK_1 : REF_CLK_0;
    rise = sref & ~st.ref_q;
    tick = 1'b0;
    sum = 9'h0;
    dlt = 8'h0;
    if (CE) begin
      // Bus slave: one wait state, unmapped reads return zero.
      next_st.ack = WB_I.cyc & WB_I.stb & ~st.ack;
      if (WB_I.cyc && WB_I.stb && !st.ack) begin
        next_st.rdat = rd(st, WB_I.adr);
        if (WB_I.we) begin
          next_st = wr(next_st, WB_I.adr, WB_I.dat, WB_I.sel);
        end
      end
      if (rc.wr.pend) begin
        next_st = wr(next_st, rc.wr.adr, rc.wr.dat, 4'hf);
      end
      // Strobes pass two flip-flops before any edge is taken.
      next_st.ds_sync = {st.ds_sync[1:0], DELAY_STEP_STROBE};
      next_st.ps_sync = {st.ps_sync[1:0], PHASE_STEP_STROBE};
      next_st.pr_sync = {st.pr_sync[1:0], PHASE_RESTORE_N};
      next_st.ref_q = sref;
      next_st.ref_sel_q = REF_SELECT;
      // Divider is released only on a reference edge, for both loops.
      if (!REF_DIVIDER_SYNC_ENABLE || !LOOP_SLEEP_N) begin
        next_st.div_run = 1'b0;
        next_st.div_cnt = 6'h0;
      end else if (rise) begin
        next_st.div_run = 1'b1;
        if (st.div_run) begin
          tick = (st.div_cnt == st.ref_div - 6'h1);
          next_st.div_cnt = tick ? 6'h0 : st.div_cnt + 6'h1;
        end
      end
      // Lock waits a power of two of divided cycles; a switch restarts.
      if (!LOOP_SLEEP_N || (REF_SELECT != st.ref_sel_q)) begin
        next_st.lock = 1'b0;
        next_st.lock_cnt = 16'h0;
      end else if (tick && !st.lock) begin
        next_st.lock_cnt = st.lock_cnt + 16'h1;
        if (st.lock_cnt + 16'h1 == (16'h1 << st.lock_exp)) begin
          next_st.lock = 1'b1;
        end
      end
      // Delay line: restore wins, ends saturate until restored.
      dlt = DELAY_DOUBLE ? 8'h2 : 8'h1;
      if (DELAY_RESTORE) begin
        next_st.tap = st.dly_init;
        next_st.lim = 1'b0;
      end else if (st.ds_sync[1] && !st.ds_sync[2] && !st.lim) begin
        if (DELAY_DIRECTION) begin
          sum = {1'b0, st.tap} + {1'b0, dlt};
          if (sum >= {1'b0, DLY_MAX}) begin
            next_st.tap = DLY_MAX;
            next_st.lim = 1'b1;
          end else begin
            next_st.tap = sum[7:0];
          end
        end else if (st.tap <= dlt) begin
          next_st.tap = 8'h0;
          next_st.lim = 1'b1;
        end else begin
          next_st.tap = st.tap - dlt;
        end
      end
      // Phase rotation by one of eight phases; restore wins.
      if (!st.pr_sync[1] && st.pr_sync[2]) begin
        next_st.phase = st.ph_init;
      end else if (st.ps_sync[1] && !st.ps_sync[2]) begin
        for (int i = 0; i < 4; i++) begin
          if (PHASE_SELECT[i]) begin
            next_st.phase[3*i +: 3] = PHASE_DIRECTION ?
              st.phase[3*i +: 3] + 3'h1 :
              st.phase[3*i +: 3] - 3'h1;
          end
        end
      end
      // Output gating: aligned start window, stop after two falls.
      next_st.en_q = OUT_EN;
      if (!LOOP_SLEEP_N) begin
        next_st.clk = 4'h0;
        next_st.run = 4'h0;
        next_st.pend = 4'h0;
        next_st.win_open = 1'b0;
        next_st.stop_cnt = 8'h0;
      end else begin
        for (int i = 0; i < 4; i++) begin
          if (OUT_EN[i] && !st.en_q[i] && !st.run[i]) begin
            next_st.pend[i] = 1'b1;
          end
          if (!OUT_EN[i] && st.run[i] && tick && st.clk[i]) begin
            next_st.stop_cnt[2*i +: 2] = st.stop_cnt[2*i +: 2] + 2'h1;
            if (st.stop_cnt[2*i] == 1'b1) begin
              next_st.run[i] = 1'b0;
              next_st.stop_cnt[2*i +: 2] = 2'h0;
            end
          end
          if (!BYPASS_APPLY_N && st.byp_sel[i]) begin
            next_st.clk[i] = st.ext_fb ? FEEDBACK_CLOCK_IN : sref;
          end else if (!next_st.run[i]) begin
            next_st.clk[i] = 1'b0;
          end else if (tick) begin
            next_st.clk[i] = ~st.clk[i];
          end
        end
        if (!st.win_open && (next_st.pend != 4'h0)) begin
          next_st.win_open = 1'b1;
          next_st.win_cnt = 5'h0;
        end else if (st.win_open) begin
          next_st.win_cnt = st.win_cnt + 5'h1;
          if (st.win_cnt == VCO_WINDOW - 5'h1) begin
            next_st.run = next_st.run | (next_st.pend & OUT_EN);
            next_st.pend = 4'h0;
            next_st.win_open = 1'b0;
          end
        end
      end
    end
  end

  // Register the control state.
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      st <= '0;
      st.ref_div <= REF_DIV_RST;
      st.lock_exp <= LOCK_EXP_RST;
      st.fb_div <= FB_DIV_RST;
      st.dly_init <= DLY_INIT_RST;
      st.tap <= DLY_INIT_RST;
      st.pr_sync <= 3'h7;
    end else begin
      st <= next_st;
    end
  end

  // Reconfig port: address phase when bit 32 set, else data phase.
  // Control bit 0 writes, bit 1 reads, bit 2 acknowledges the interrupt.
  always_comb begin
    next_rc = rc;
    next_rc.wr.pend = 1'b0;
    if (CE) begin
      next_rc.ck_sync = {rc.ck_sync[0], RECONFIG_CLOCK};
      next_rc.ck_q = rc.ck_sync[1];
      next_rc.lock_q = st.lock;
      if (rc.ck_sync[1] && !rc.ck_q) begin
        if (RECONFIG_CONTROL[0]) begin
          if (RECONFIG_WRITE_BUS[32]) begin
            next_rc.adr = RECONFIG_WRITE_BUS[7:0];
          end else begin
            next_rc.wr = {1'b1, rc.adr, RECONFIG_WRITE_BUS[31:0]};
          end
        end
        if (RECONFIG_CONTROL[1]) begin
          next_rc.rbus = {1'b0, rd(st, rc.adr)};
        end
        if (RECONFIG_CONTROL[2]) begin
          next_rc.irq = 1'b0;
        end
      end
      if (st.lock != rc.lock_q) begin
        next_rc.irq = 1'b1;
      end
    end
  end

  // The reconfig port clears at once on its own reset.
  always_ff @(posedge CLOCK or negedge RECONFIG_RESET_N) begin
    if (!RECONFIG_RESET_N) begin
      rc <= '0;
    end else if (!RESETN) begin
      rc <= '0;
    end else begin
      rc <= next_rc;
    end
  end

  assign WB_ACK_O = st.ack;
  assign WB_DAT_O = st.rdat;
  assign CLK_OUT = st.clk;
  assign LOCK = st.lock;
  assign REF_DIV_RUN = {2{st.div_run}};
  assign DELAY_LIMIT_REACHED = st.lim;
  assign DELAY_TAP = st.tap;
  assign PHASE_OFFSET = st.phase;
  assign RECONFIG_READ_BUS = rc.rbus;
  assign RECONFIG_IRQ = rc.irq;

  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESETN);

  sleep_outputs_a: assert property (CE && !LOOP_SLEEP_N |=>
    CLK_OUT == 4'h0 && !LOCK) else $error("sleep left outputs on");
  ref_div_a: assert property (st.ref_div != 6'h0)
    else $error("reference ratio zero");
  fb_div_a: assert property (fb_ok(st.fraction_word_mode, st.fb_div))
    else $error("feedback ratio out of range");
  delay_restore_a: assert property (CE && DELAY_RESTORE |=>
    DELAY_TAP == $past(st.dly_init) && !DELAY_LIMIT_REACHED)
    else $error("restore did not reload delay");
  delay_limit_a: assert property (CE && st.lim && !DELAY_RESTORE |=>
    $stable(DELAY_TAP) && DELAY_LIMIT_REACHED)
    else $error("delay moved past limit");
  delay_step_a: assert property (CE && st.ds_sync[1] && !st.ds_sync[2] &&
    !DELAY_RESTORE && !st.lim && DELAY_DIRECTION && DELAY_DOUBLE &&
    st.tap < 8'hf0 |=> DELAY_TAP == $past(st.tap) + 8'h2)
    else $error("double step wrong");
  wb_ack_a: assert property (CE && WB_I.cyc && WB_I.stb && !st.ack |=>
    WB_ACK_O ##1 !WB_ACK_O || !CE) else $error("ack not one cycle");
  irq_hold_a: assert property (@(posedge CLOCK)
    disable iff (!RECONFIG_RESET_N || !RESETN)
    RECONFIG_IRQ && !(rc.ck_sync[1] && !rc.ck_q && RECONFIG_CONTROL[2])
    |=> RECONFIG_IRQ) else $error("irq dropped before service");
endmodule

// >>> pfc_fabric_model.sv
// Fabric-side stand-in: the two reference sources and the feedback loop.
// Assumes CLOCK is the system clock and references are sampled levels.
`timescale 1ns/1ps
module pfc_fabric_model
  import pfc_pkg::*;
(
  input wire logic CLOCK, // System clock.
  input wire logic [3:0] CLK_OUT, // Synthesizer outputs.
  output logic REF_CLK_0, // Primary reference.
  output logic REF_CLK_1, // Backup reference.
  output logic FEEDBACK_CLOCK_IN // Looped-back output.
);
  logic [2:0] span = 3'h0; // Shared period counter.

  // One period for both sources, a quarter apart, as two origins would be.
  always @(posedge CLOCK) begin
    span <= span + 3'h1;
    REF_CLK_0 <= span[2];
    REF_CLK_1 <= span[2] ^ span[1];
  end

  // The first output returns as the external feedback clock.
  assign FEEDBACK_CLOCK_IN = CLK_OUT[0];
endmodule

// >>> pfc_ctrl_tb.sv
// Self-checking bench for the synthesizer fabric control block.
// Assumes the fabric model supplies references and feedback.
`timescale 1ns/1ps
module pfc_ctrl_tb
  import pfc_pkg::*;
;
  logic clock = 1'b0; // System clock.
  logic resetn = 1'b0; // Held low at start.
  pfc_wb_t wb = '0; // Bus request.
  logic ack, fb, r0, r1, irq, lock, lim; // Design outputs and refs.
  logic [31:0] rdat, rd; // Bus read data.
  logic sel = 1'b0, byp_n = 1'b1, sync_en = 1'b0, ce = 1'b1; // Controls.
  logic sleep_n = 1'b0; // Low until the references run.
  logic [3:0] oe = 4'h0, psel = 4'h0; // Enables and phase picks.
  logic dstb = 0, ddir = 0, ddbl = 0, drst = 0; // Delay controls.
  logic pdir = 0, pstb = 0, prst_n = 1, rclk = 0, rrst_n = 1;
  logic [10:0] rctl = 11'h000; // Reconfig control.
  logic [32:0] rwb = 33'h0, rrb; // Reconfig buses.
  logic [3:0] clk_out; // Gated outputs.
  logic [1:0] div_run; // Divider run flags.
  logic [7:0] tap; // Delay tap.
  logic [11:0] phoff; // Phase offsets.
  logic [11:0] exp_fb = FB_DIV_RST; // Expected feedback ratio.
  logic [11:0] fb_tab [11] = '{12'h007, 12'h008, 12'h00a, 12'h00b,
    12'h00c, 12'hfff, 12'h014, 12'h013, 12'h014, 12'h1f4, 12'h1f5};
  logic tog = 0, bad = 0; // Output activity and misalignment.
  int err_total = 0, check_count = 0, n; // Tallies and a wait count.

  always #25 clock = ~clock;

  pfc_ctrl pfc_ctrl_i (.CLOCK(clock), .RESETN(resetn), .CE(ce),
    .WB_I(wb), .WB_ACK_O(ack), .WB_DAT_O(rdat), .REF_CLK_0(r0),
    .REF_CLK_1(r1), .REF_SELECT(sel), .FEEDBACK_CLOCK_IN(fb),
    .LOOP_SLEEP_N(sleep_n), .OUT_EN(oe), .BYPASS_APPLY_N(byp_n),
    .REF_DIVIDER_SYNC_ENABLE(sync_en), .DELAY_STEP_STROBE(dstb),
    .DELAY_DIRECTION(ddir), .DELAY_DOUBLE(ddbl), .DELAY_RESTORE(drst),
    .PHASE_SELECT(psel), .PHASE_DIRECTION(pdir),
    .PHASE_STEP_STROBE(pstb), .PHASE_RESTORE_N(prst_n),
    .RECONFIG_CLOCK(rclk), .RECONFIG_RESET_N(rrst_n),
    .RECONFIG_CONTROL(rctl), .RECONFIG_WRITE_BUS(rwb),
    .RECONFIG_READ_BUS(rrb), .RECONFIG_IRQ(irq), .CLK_OUT(clk_out),
    .LOCK(lock), .REF_DIV_RUN(div_run), .DELAY_LIMIT_REACHED(lim),
    .DELAY_TAP(tap), .PHASE_OFFSET(phoff));

  pfc_fabric_model pfc_fabric_model_i (.CLOCK(clock), .CLK_OUT(clk_out),
    .REF_CLK_0(r0), .REF_CLK_1(r1), .FEEDBACK_CLOCK_IN(fb));

  // Compares one value; unknowns never match.
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic wrap_up();
    if (err_total == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic cycles(input int k);
    repeat (k) @(posedge clock);
  endtask

  // One classic cycle; the request holds until ack is seen at an edge.
  task automatic wb_xfer(input logic we, input logic [7:0] a,
                         input logic [31:0] d);
    @(posedge clock);
    wb <= '{cyc:1'b1, stb:1'b1, we:we, adr:a, sel:4'hf, dat:d};
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      wrap_up();
    end
    rd = rdat;
    wb <= '0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    wb_xfer(1'b0, a, 32'h0);
    chk({1'b0, rd}, {1'b0, e});
  endtask

  // Strobes are held long enough for the resynchroniser to see them.
  task automatic pulse(input logic ph);
    @(posedge clock);
    if (ph) pstb <= 1'b1;
    else dstb <= 1'b1;
    cycles(6);
    pstb <= 1'b0;
    dstb <= 1'b0;
    cycles(6);
  endtask

  task automatic step(input logic dir, input logic dbl);
    ddir <= dir;
    ddbl <= dbl;
    pulse(1'b0);
  endtask

  // Applies a bypass setting; output three must follow its source one
  // cycle late, the feedback input when cfg[7] is set, else the chosen
  // reference.
  task automatic byp_chk(input logic [31:0] cfg);
    logic prev;
    wb_xfer(1'b1, ADR_DIVCFG, cfg);
    byp_n <= 1'b0;
    bad = 1'b0;
    cycles(2);
    prev = cfg[7] ? fb : (sel ? r1 : r0);
    repeat (16) begin
      @(posedge clock);
      bad |= clk_out[3] ^ prev;
      prev = cfg[7] ? fb : (sel ? r1 : r0);
    end
    byp_n <= 1'b1;
    chk(bad, 1'b0);
  endtask

  // One reconfig clock period, high well past the detection latency.
  task automatic rc(input logic [10:0] c, input logic [32:0] w);
    rctl <= c;
    rwb <= w;
    cycles(1);
    rclk <= 1'b1;
    cycles(5);
    rclk <= 1'b0;
    cycles(5);
  endtask

  // Legal feedback ratios, worked out independently of the design.
  function automatic logic legal(input logic [11:0] v, input logic f);
    if (f) return v >= FB_FRACTION_WORD_LO && v <= FB_FRACTION_WORD_HI;
    return (v >= FB_INT_LO && v <= FB_INT_HI1) || v >= FB_INT_LO2;
  endfunction

  initial begin
    cycles(6);
    resetn <= 1'b1;
    cycles(1);
    chk({lock, irq, lim, clk_out, div_run}, 33'h0);
    chk(tap, DLY_INIT_RST);
    chk(rrb, 33'h0);
    rdchk(ADR_DIVCFG, {20'h0, LOCK_EXP_RST, 2'b00, REF_DIV_RST});
    rdchk(8'h3c, 32'h0);
    // A zero ratio is refused and flags the error bit.
    wb_xfer(1'b1, ADR_DIVCFG, {20'h0, LOCK_EXP_RST, 8'h00});
    rdchk(ADR_DIVCFG, {20'h0, LOCK_EXP_RST, 2'b00, REF_DIV_RST});
    rdchk(ADR_STATUS, {16'h0, DLY_INIT_RST, 8'h0c});
    chk(rd[ERR_BIT], 1'b1);
    wb_xfer(1'b1, ADR_STATUS, 32'h1 << ERR_BIT);
    rdchk(ADR_STATUS, {16'h0, DLY_INIT_RST, 8'h08});
    chk(rd[ERR_BIT], 1'b0);
    wb_xfer(1'b1, ADR_DIVCFG, {20'h0, LOCK_EXP_RST, 2'b00, REF_DIV_MAX});
    rdchk(ADR_DIVCFG, {20'h0, LOCK_EXP_RST, 2'b00, REF_DIV_MAX});
    // Band edges in integer mode, then in fractional mode.
    for (int i = 0; i < 11; i++) begin
      if (i == 7) wb_xfer(1'b1, ADR_DIVCFG, 32'h841);
      wb_xfer(1'b1, ADR_FEEDBACK_DIVIDER, {20'h0, fb_tab[i]});
      if (legal(fb_tab[i], i >= 7)) exp_fb = fb_tab[i];
      rdchk(ADR_FEEDBACK_DIVIDER, {20'h0, exp_fb});
    end
    wb_xfer(1'b1, ADR_FRACTION_WORD, 32'hffff_ffff);
    rdchk(ADR_FRACTION_WORD, 32'h00ff_ffff);
    step(1'b1, 1'b0);
    chk(tap, 8'h41);
    step(1'b1, 1'b1);
    chk(tap, 8'h43);
    step(1'b0, 1'b1);
    chk(tap, 8'h41);
    step(1'b0, 1'b0);
    chk(tap, 8'h40);
    // With the clock enable low the strobe never reaches the synchroniser.
    ce <= 1'b0;
    step(1'b1, 1'b0);
    chk(tap, 8'h40);
    ce <= 1'b1;
    drst <= 1'b1;
    step(1'b1, 1'b0);
    chk(tap, 8'h40);
    drst <= 1'b0;
    for (int i = 0; i < 32; i++) begin
      step(1'b0, 1'b1);
      chk(tap, 8'h40 - 8'(2 * (i + 1)));
    end
    step(1'b1, 1'b0);
    chk({lim, tap}, 9'h100);
    drst <= 1'b1;
    cycles(6);
    chk({lim, tap}, 9'h040);
    drst <= 1'b0;
    psel <= 4'b0101;
    pdir <= 1'b1;
    pulse(1'b1);
    chk(phoff, 12'h041);
    psel <= 4'b0001;
    pdir <= 1'b0;
    pulse(1'b1);
    chk(phoff, 12'h040);
    prst_n <= 1'b0;
    cycles(6);
    chk(phoff, 12'h000);
    prst_n <= 1'b1;
    // Shortest lock delay, ratio one, both dividers released together.
    wb_xfer(1'b1, ADR_DIVCFG, {20'h0, LOCK_EXP_MIN, 2'b00, REF_DIV_RST});
    sleep_n <= 1'b1;
    sync_en <= 1'b1;
    n = 0;
    while (lock !== 1'b1 && n < 400) begin
      @(posedge clock);
      n++;
    end
    if (n >= 400) begin
      err_total++;
      wrap_up();
    end
    chk(lock, 1'b1);
    chk(div_run, 2'b11);
    cycles(10);
    chk(irq, 1'b1);
    rc(11'h004, 33'h0);
    chk(irq, 1'b0);
    rc(11'h001, {25'h1000000, ADR_DLYINIT});
    rc(11'h001, 33'h050);
    rc(11'h002, 33'h0);
    chk(rrb, 33'h050);
    drst <= 1'b1;
    cycles(6);
    chk(tap, 8'h50);
    drst <= 1'b0;
    oe <= 4'b0011;
    repeat (80) begin
      @(posedge clock);
      tog |= clk_out[0];
      bad |= (clk_out[0] ^ clk_out[1]) | (|clk_out[3:2]);
    end
    chk({bad, tog}, 2'b01);
    oe <= 4'b0010;
    cycles(40);
    chk(clk_out[0], 1'b0);
    // A stopped output must stay low for a whole divided period.
    tog = 1'b0;
    repeat (16) begin
      @(posedge clock);
      tog |= clk_out[0];
    end
    chk(tog, 1'b0);
    sel <= 1'b1;
    byp_chk({16'h0, 4'h8, LOCK_EXP_MIN, 2'b00, REF_DIV_RST});
    byp_chk({16'h0, 4'h8, LOCK_EXP_MIN, 2'b10, REF_DIV_RST});
    sleep_n <= 1'b0;
    cycles(8);
    chk({lock, clk_out, irq}, 6'h01);
    rdchk(ADR_STATUS, {16'h0, 8'h50, 8'h1c});
    chk(rd[4:3], 2'b11);
    @(posedge clock);
    rrst_n <= 1'b0;
    #1;
    chk(irq, 1'b0);
    cycles(2);
    rrst_n <= 1'b1;
    wrap_up();
  end
endmodule
